// >>> logic/pct_cfg.svh
`ifndef PCT_CFG_SVH
`define PCT_CFG_SVH

// apb register byte addresses
`define PCT_CTRL_ADDR 8'h00
`define PCT_STATUS_ADDR 8'h04
`define PCT_EVENT_ADDR 8'h08
`define PCT_BATT_ADDR 8'h0c

// control register fields
`define PCT_CTRL_W 6
`define PCT_CTRL_PWR 0
`define PCT_CTRL_SENSE 1
`define PCT_CTRL_BACKUP 2
`define PCT_CTRL_AUXTR 3
`define PCT_CTRL_SYSRST 4
`define PCT_CTRL_GAINIT 5
`define PCT_CTRL_RST 6'h00

// event register fields (write one to clear)
`define PCT_EVT_W 3
`define PCT_EVT_OFF 0
`define PCT_EVT_ON 1
`define PCT_EVT_ADP 2
`define PCT_EVT_RST 3'h0

// battery register: level in 7:0, threshold in 15:8
`define PCT_LEVEL_LSB 0
`define PCT_THRESH_LSB 8
`define PCT_LEVEL_RST 8'hff
`define PCT_THRESH_RST 8'h80

// status register fields
`define PCT_ST_PSW 0
`define PCT_ST_RSW 1
`define PCT_ST_ADP 2
`define PCT_ST_STRAP 3
`define PCT_ST_STATE_LSB 4
`define PCT_ST_HOURS_LSB 8
`define PCT_ST_LIMIT_LSB 12

// charge timing
`define PCT_HOURS_PWR_ON 4'hb
`define PCT_HOURS_PWR_OFF 4'h8
`define PCT_CLK_HZ 64'h5f5e100
`define PCT_HOUR_S 64'he10
`define PCT_PRESC_W 39

`endif

// >>> logic/pct_pkg.sv
package pct_pkg;

  // gray order along idle -> normal -> trickle; free is the strap mode
  typedef enum logic [1:0] {
    ch_idle = 2'b00,
    ch_normal = 2'b01,
    ch_trickle = 2'b11,
    ch_free = 2'b10
  } pct_charge_t;

endpackage

// >>> logic/pct_prescale.sv
`timescale 1ns/1ns
`default_nettype none

module pct_prescale #(
  parameter int W = 8,
  parameter longint unsigned LIMIT = 64'h100
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclk_en,
  input wire logic clear,
  output logic tick_reg
);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;
  logic tick_next;

  localparam logic [W-1:0] LAST = W'(LIMIT - 64'h1);

  always_comb begin
    count_next = count_reg;
    tick_next = 1'b0;
    if (clear) begin
      count_next = '0;
    end else if (count_reg == LAST) begin
      count_next = '0;
      tick_next = 1'b1;
    end else begin
      count_next = count_reg + W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= '0;
      tick_reg <= 1'b0;
    end else if (pclk_en) begin
      count_reg <= count_next;
      tick_reg <= tick_next;
    end
  end

endmodule // pct_prescale

`default_nettype wire

// >>> logic/pct_power_charge.sv
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "pct_cfg.svh"

module pct_power_charge
  import pct_pkg::*;
#(
  parameter longint unsigned HOUR_CYCLES = `PCT_CLK_HZ * `PCT_HOUR_S
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic power_switch_input,
  input wire logic reset_switch_input,
  input wire logic adaptor_detect_input,
  input wire logic charge_control_strap,
  output logic battery_sense_enable,
  output logic system_reset_output_n,
  output logic main_charge_mode_output,
  output logic backup_source_select,
  output logic aux_charge_mode_output,
  output logic power_enable_output_n,
  output logic gate_array_init_output_n
);

  // pin synchronisers: s1 is read only by s2, s3 keeps the previous level
  logic [3:0] pins_in;
  logic [3:0] pins_s1_reg;
  logic [3:0] pins_s2_reg;
  logic [3:0] pins_s3_reg;
  logic psw_s2, psw_s3, rsw_s2, adp_s2, adp_s3, strap_s2;

  assign pins_in = {charge_control_strap, adaptor_detect_input,
                    reset_switch_input, power_switch_input};
  assign psw_s2 = pins_s2_reg[0];
  assign psw_s3 = pins_s3_reg[0];
  assign rsw_s2 = pins_s2_reg[1];
  assign adp_s2 = pins_s2_reg[2];
  assign adp_s3 = pins_s3_reg[2];
  assign strap_s2 = pins_s2_reg[3];

  // inactive pin levels at reset keep spurious edges away
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_s1_reg <= 4'h3;
      pins_s2_reg <= 4'h3;
      pins_s3_reg <= 4'h3;
    end else if (pclk_en) begin
      pins_s1_reg <= pins_in;
      pins_s2_reg <= pins_s1_reg;
      pins_s3_reg <= pins_s2_reg;
    end
  end

  // apb slave and software registers
  logic [`PCT_CTRL_W-1:0] ctrl_reg, ctrl_next;
  logic [`PCT_EVT_W-1:0] evt_reg, evt_next;
  logic [7:0] level_reg, level_next;
  logic [7:0] thresh_reg, thresh_next;
  logic [31:0] prdata_next;
  logic pready_next, pslverr_next;
  logic [31:0] status_word;
  logic wr_en, setup, mapped;
  logic [`PCT_EVT_W-1:0] evt_set;
  pct_charge_t state_reg, state_next;
  logic [3:0] hours_reg, hours_next;
  logic [3:0] limit_reg, limit_next;

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite;
  assign mapped = (paddr == `PCT_CTRL_ADDR) || (paddr == `PCT_STATUS_ADDR) ||
                  (paddr == `PCT_EVENT_ADDR) || (paddr == `PCT_BATT_ADDR);

  always_comb begin
    status_word = 32'h0;
    status_word[`PCT_ST_PSW] = psw_s2;
    status_word[`PCT_ST_RSW] = rsw_s2;
    status_word[`PCT_ST_ADP] = adp_s2;
    status_word[`PCT_ST_STRAP] = strap_s2;
    status_word[`PCT_ST_STATE_LSB +: 2] = state_reg;
    status_word[`PCT_ST_HOURS_LSB +: 4] = hours_reg;
    status_word[`PCT_ST_LIMIT_LSB +: 4] = limit_reg;
  end

  // switch edges become power on and off requests
  always_comb begin
    evt_set = '0;
    evt_set[`PCT_EVT_OFF] = psw_s3 && !psw_s2;
    evt_set[`PCT_EVT_ON] = !psw_s3 && psw_s2;
    evt_set[`PCT_EVT_ADP] = !adp_s3 && adp_s2;
  end

  always_comb begin
    ctrl_next = ctrl_reg;
    level_next = level_reg;
    thresh_next = thresh_reg;
    evt_next = evt_reg;
    // a set in the clearing cycle survives
    if (wr_en && paddr == `PCT_EVENT_ADDR) begin
      evt_next = evt_reg & ~pwdata[`PCT_EVT_W-1:0];
    end
    evt_next = evt_next | evt_set;
    if (wr_en && paddr == `PCT_CTRL_ADDR) begin
      ctrl_next = pwdata[`PCT_CTRL_W-1:0];
    end
    if (wr_en && paddr == `PCT_BATT_ADDR) begin
      level_next = pwdata[`PCT_LEVEL_LSB +: 8];
      thresh_next = pwdata[`PCT_THRESH_LSB +: 8];
    end
    // zero-wait answer: ready in the first access cycle
    pready_next = setup;
    pslverr_next = setup && !mapped;
    prdata_next = prdata;
    if (setup) begin
      unique case (paddr)
        `PCT_CTRL_ADDR: prdata_next = {{(32-`PCT_CTRL_W){1'b0}}, ctrl_reg};
        `PCT_STATUS_ADDR: prdata_next = status_word;
        `PCT_EVENT_ADDR: prdata_next = {{(32-`PCT_EVT_W){1'b0}}, evt_reg};
        `PCT_BATT_ADDR: prdata_next = {16'h0, thresh_reg, level_reg};
        default: prdata_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `PCT_CTRL_RST;
      evt_reg <= `PCT_EVT_RST;
      level_reg <= `PCT_LEVEL_RST;
      thresh_reg <= `PCT_THRESH_RST;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (pclk_en) begin
      ctrl_reg <= ctrl_next;
      evt_reg <= evt_next;
      level_reg <= level_next;
      thresh_reg <= thresh_next;
      prdata <= prdata_next;
      pready <= pready_next;
      pslverr <= pslverr_next;
    end
  end

  // charge timer
  logic hour_tick, tb_clear, batt_low, power_on, restart;

  assign batt_low = level_reg <= thresh_reg;
  assign power_on = !power_enable_output_n;
  // timebase restarts with each interval and stays cleared without adaptor
  assign tb_clear = !adp_s2 || restart;

  pct_prescale #(
    .W(`PCT_PRESC_W),
    .LIMIT(HOUR_CYCLES)
  ) i_pct_prescale (
    .pclk(pclk),
    .presetn(presetn),
    .pclk_en(pclk_en),
    .clear(tb_clear),
    .tick_reg(hour_tick)
  );

  always_comb begin
    state_next = state_reg;
    hours_next = hours_reg;
    limit_next = limit_reg;
    restart = 1'b0;
    if (!adp_s2) begin
      state_next = ch_idle;
      hours_next = 4'h0;
    end else if (strap_s2) begin
      state_next = ch_free;
      hours_next = 4'h0;
    end else begin
      unique case (state_reg)
        ch_idle, ch_free: begin
          // every connection starts over, history ignored
          state_next = ch_normal;
          hours_next = 4'h0;
          restart = 1'b1;
          limit_next = power_on ? `PCT_HOURS_PWR_ON : `PCT_HOURS_PWR_OFF;
        end
        ch_normal: begin
          // battery level deliberately not looked at here
          if (hours_reg == limit_reg) begin
            state_next = ch_trickle;
          end else if (hour_tick) begin
            hours_next = hours_reg + 4'h1;
          end
        end
        ch_trickle: begin
          if (batt_low) begin
            state_next = ch_normal;
            hours_next = 4'h0;
            restart = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ch_idle;
      hours_reg <= 4'h0;
      limit_reg <= `PCT_HOURS_PWR_OFF;
    end else if (pclk_en) begin
      state_reg <= state_next;
      hours_reg <= hours_next;
      limit_reg <= limit_next;
    end
  end

  // port drivers, all registered
  logic sense_next, sysrst_n_next, main_mode_next, backup_next;
  logic aux_mode_next, pwr_n_next, ga_n_next;

  always_comb begin
    sense_next = ctrl_reg[`PCT_CTRL_SENSE];
    sysrst_n_next = !(ctrl_reg[`PCT_CTRL_SYSRST] || !rsw_s2);
    ga_n_next = !(ctrl_reg[`PCT_CTRL_GAINIT] || !rsw_s2);
    main_mode_next = state_next == ch_trickle;
    backup_next = ctrl_reg[`PCT_CTRL_BACKUP];
    aux_mode_next = ctrl_reg[`PCT_CTRL_AUXTR];
    pwr_n_next = !ctrl_reg[`PCT_CTRL_PWR];
  end

  // logic supply stays off until software asks for it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      battery_sense_enable <= 1'b0;
      system_reset_output_n <= 1'b1;
      gate_array_init_output_n <= 1'b1;
      power_enable_output_n <= 1'b1;
      main_charge_mode_output <= 1'b0;
      backup_source_select <= 1'b0;
      aux_charge_mode_output <= 1'b0;
    end else if (pclk_en) begin
      battery_sense_enable <= sense_next;
      system_reset_output_n <= sysrst_n_next;
      gate_array_init_output_n <= ga_n_next;
      power_enable_output_n <= pwr_n_next;
      main_charge_mode_output <= main_mode_next;
      backup_source_select <= backup_next;
      aux_charge_mode_output <= aux_mode_next;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  switch_edge_flag_a: assert property (
    pclk_en && psw_s3 && !psw_s2 |=> evt_reg[`PCT_EVT_OFF])
    else $error("power switch fall not flagged");

  switch_rise_flag_a: assert property (
    pclk_en && !psw_s3 && psw_s2 |=> evt_reg[`PCT_EVT_ON])
    else $error("power switch rise not flagged");

  sense_follows_ctrl_a: assert property (
    pclk_en && ctrl_reg[`PCT_CTRL_SENSE] |=> battery_sense_enable)
    else $error("sense enable not driven");

  reset_switch_src_a: assert property (
    pclk_en && !rsw_s2 |=> !system_reset_output_n && !gate_array_init_output_n)
    else $error("reset switch did not assert both resets");

  sw_sysreset_a: assert property (
    pclk_en && ctrl_reg[`PCT_CTRL_SYSRST] |=> !system_reset_output_n)
    else $error("software reset not driven low");

  ga_init_a: assert property (
    pclk_en && ctrl_reg[`PCT_CTRL_GAINIT] |=> !gate_array_init_output_n)
    else $error("gate array init not driven low");

  main_mode_map_a: assert property (
    main_charge_mode_output == (state_reg == ch_trickle))
    else $error("charge mode output disagrees with state");

  power_en_map_a: assert property (
    pclk_en |=> power_enable_output_n == !$past(ctrl_reg[`PCT_CTRL_PWR]))
    else $error("power enable level wrong");

  strap_free_a: assert property (
    pclk_en && adp_s2 && strap_s2 |=> state_reg == ch_free && !main_charge_mode_output)
    else $error("strap closed but charge not continuous");

  connect_limit_a: assert property (
    pclk_en && adp_s2 && !strap_s2 && state_reg == ch_idle |=>
      state_reg == ch_normal && hours_reg == 4'h0 &&
      limit_reg == ($past(power_on) ? `PCT_HOURS_PWR_ON : `PCT_HOURS_PWR_OFF))
    else $error("wrong interval chosen at connection");

  timed_hold_a: assert property (
    pclk_en && adp_s2 && !strap_s2 && state_reg == ch_normal && hours_reg != limit_reg
      |=> state_reg == ch_normal)
    else $error("normal interval left early");

  expiry_trickle_a: assert property (
    pclk_en && adp_s2 && !strap_s2 && state_reg == ch_normal && hours_reg == limit_reg
      |=> state_reg == ch_trickle ##0 main_charge_mode_output)
    else $error("no trickle after interval");

  low_batt_return_a: assert property (
    pclk_en && adp_s2 && !strap_s2 && state_reg == ch_trickle && batt_low
      |=> state_reg == ch_normal && hours_reg == 4'h0)
    else $error("low battery did not restart normal charge");

  unplug_clear_a: assert property (
    pclk_en && !adp_s2 |=> state_reg == ch_idle && hours_reg == 4'h0)
    else $error("disconnect did not abort interval");

  backup_aux_map_a: assert property (
    pclk_en |=> backup_source_select == $past(ctrl_reg[`PCT_CTRL_BACKUP]) &&
      aux_charge_mode_output == $past(ctrl_reg[`PCT_CTRL_AUXTR]))
    else $error("backup or aux charge level wrong");

  hour_clear_a: assert property (
    pclk_en && !adp_s2 |=> !hour_tick)
    else $error("hour timebase ran without adaptor");

endmodule // pct_power_charge

`default_nettype wire

// >>> tb/pct_far_side.sv
`timescale 1ns/1ns
`default_nettype none

module pct_far_side (
  input wire logic pclk,
  input wire logic power_enable_output_n,
  output logic power_switch_input,
  output logic reset_switch_input,
  output logic adaptor_detect_input,
  output logic charge_control_strap
);
  // switches idle at their pulled-up open level, adaptor unplugged, strap open
  initial begin
    power_switch_input = 1'b1;
    reset_switch_input = 1'b1;
    adaptor_detect_input = 1'b0;
    charge_control_strap = 1'b0;
  end

  // called right after a rising edge, so pins move off the sampling edge
  task automatic drive(input logic psw, input logic rsw, input logic adp, input logic strap);
    power_switch_input <= psw;
    reset_switch_input <= rsw;
    adaptor_detect_input <= adp;
    charge_control_strap <= strap;
  endtask
endmodule // pct_far_side

`default_nettype wire

// >>> tb/test_power_port_and_charge_timer.sv
`timescale 1ns/1ns
`default_nettype none

module test_power_port_and_charge_timer;
  localparam int HC = 20;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic pclk_en = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, e, psw, rsw, adp, strap;
  logic sense, sr_n, main_cm, bk, aux, pe_n, ga_n;
  int error_cnt = 0, n_checks = 0;

  always #5 pclk = ~pclk;

  pct_power_charge #(.HOUR_CYCLES(HC)) i_pct_power_charge (.pclk(pclk), .presetn(presetn),
    .pclk_en(pclk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_switch_input(psw), .reset_switch_input(rsw), .adaptor_detect_input(adp),
    .charge_control_strap(strap), .battery_sense_enable(sense),
    .system_reset_output_n(sr_n), .main_charge_mode_output(main_cm),
    .backup_source_select(bk), .aux_charge_mode_output(aux),
    .power_enable_output_n(pe_n), .gate_array_init_output_n(ga_n));

  pct_far_side i_pct_far_side (.pclk(pclk), .power_enable_output_n(pe_n),
    .power_switch_input(psw), .reset_switch_input(rsw), .adaptor_detect_input(adp),
    .charge_control_strap(strap));

  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // one apb transfer; one idle cycle after so psel is never set twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
    if (n >= 20) begin
      error_cnt++;
      $display("ERROR %0t apb wait ran out", $time);
      final_report();
    end
  endtask

  task automatic drv(input logic p, input logic r, input logic a, input logic s);
    i_pct_far_side.drive(p, r, a, s);
  endtask

  // normal until the interval ends, trickle shortly after
  task automatic timed(input int lim, input int spent);
    cyc(lim * HC - 5 - spent);
    chk({31'h0, main_cm}, 32'h0, "still normal");
    cyc(15);
    chk({31'h0, main_cm}, 32'h1, "trickle after interval");
  endtask

  task automatic t_reset_ctrl;
    logic [5:0] v;
    chk({26'h0, ga_n, sr_n, pe_n, main_cm, sense, bk}, 32'h38, "reset levels");
    for (int b = 0; b < 6; b++) begin
      v = 6'h01 << b;
      apb(1'b1, 8'h00, {26'h0, v});
      cyc(3);
      chk({26'h0, ga_n, sr_n, aux, bk, sense, pe_n},
          {26'h0, ~v[5], ~v[4], v[3], v[2], v[1], ~v[0]}, "ctrl to pins");
    end
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, e}, 32'h1, "unmapped error");
  endtask

  task automatic t_events;
    drv(1'b0, 1'b1, 1'b0, 1'b0);
    cyc(5);
    apb(1'b0, 8'h08, 32'h0);
    chk(q & 32'h3, 32'h1, "off edge event");
    apb(1'b1, 8'h08, 32'h7);
    drv(1'b1, 1'b1, 1'b0, 1'b0);
    cyc(5);
    apb(1'b0, 8'h08, 32'h0);
    chk(q & 32'h3, 32'h2, "on edge event");
    drv(1'b1, 1'b0, 1'b0, 1'b0);
    cyc(5);
    chk({30'h0, sr_n, ga_n}, 32'h0, "reset switch asserts both");
    drv(1'b1, 1'b1, 1'b0, 1'b0);
    cyc(5);
    chk({30'h0, sr_n, ga_n}, 32'h3, "reset switch released");
  endtask

  task automatic t_charge;
    drv(1'b1, 1'b1, 1'b1, 1'b1);
    cyc(5);
    apb(1'b0, 8'h04, 32'h0);
    chk(q & 32'hc, 32'hc, "adaptor and strap seen");
    cyc(250);
    chk({31'h0, main_cm}, 32'h0, "strap keeps normal");
    drv(1'b1, 1'b1, 1'b0, 1'b0);
    cyc(5);
    drv(1'b1, 1'b1, 1'b1, 1'b0);
    cyc(6);
    apb(1'b1, 8'h00, 32'h1);
    timed(8, 10);
    apb(1'b1, 8'h0c, 32'h8080);
    cyc(5);
    chk({31'h0, main_cm}, 32'h0, "low battery back to normal");
    apb(1'b1, 8'h0c, 32'h80ff);
    timed(8, 12);
    drv(1'b1, 1'b1, 1'b0, 1'b0);
    apb(1'b1, 8'h00, 32'h0);
    cyc(3);
    drv(1'b1, 1'b1, 1'b1, 1'b0);
    cyc(80);
    drv(1'b1, 1'b1, 1'b0, 1'b0);
    cyc(8);
    apb(1'b0, 8'h04, 32'h0);
    chk({28'h0, q[11:8]}, 32'h0, "hours cleared");
    chk({31'h0, main_cm}, 32'h0, "unplugged output normal");
    drv(1'b1, 1'b1, 1'b1, 1'b0);
    timed(8, 0);
    drv(1'b1, 1'b1, 1'b0, 1'b0);
    apb(1'b1, 8'h00, 32'h1);
    cyc(3);
    drv(1'b1, 1'b1, 1'b1, 1'b0);
    timed(11, 0);
  endtask

  // enable low for 40 edges must stretch the interval by exactly 40 cycles
  task automatic t_freeze;
    drv(1'b1, 1'b1, 1'b0, 1'b0);
    cyc(5);
    drv(1'b1, 1'b1, 1'b1, 1'b0);
    cyc(10);
    pclk_en <= 1'b0;
    cyc(40);
    pclk_en <= 1'b1;
    timed(11, 7);
  endtask

  initial begin
    cyc(8);
    presetn <= 1'b1;
    cyc(2);
    t_reset_ctrl();
    t_events();
    t_charge();
    t_freeze();
    final_report();
  end
endmodule // test_power_port_and_charge_timer

`default_nettype wire
